// ===== rtl/ledd_core.sv
// led dimmer target core: two-wire bus target, register file, eight channels
// assumes scl and sda arrive asynchronously and the far side follows the bus protocol
`timescale 1ns/1ps
module ledd_core
    import ledd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic [3:0] addr_strap,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic [7:0] led_n,
    output logic standby
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        logic [1:0] rst_s;
        ledd_bus_st_t st;
        logic [3:0] bitc;
        logic [7:0] shift;
        logic rw;
        logic first;
        logic is_srst;
        logic [1:0] srst_cnt;
        logic srst_ok;
        logic ack;
        logic drive_low;
        logic [4:0] ptr;
        logic [7:0] mode1;
        logic [7:0] mode2;
        logic [7:0][7:0] duty;
        logic [7:0] gduty;
        logic [7:0] gfreq;
        logic [15:0] ostate;
        logic [7:0] sub1;
        logic [7:0] sub2;
        logic [7:0] sub3;
        logic [7:0] gcall;
        logic stby;
    } ledd_core_t;

    ledd_core_t st_reg, st_next;
    logic scl, sda, scl_rise, scl_fall, start_c, stop_c, rst_pin;
    logic [6:0] a7;
    logic addr_hit;
    logic [7:0] rdata;

    assign scl = st_reg.scl_s[1];
    assign sda = st_reg.sda_s[1];
    assign rst_pin = ~st_reg.rst_s[1];
    assign scl_rise = scl & ~st_reg.scl_d;
    assign scl_fall = ~scl & st_reg.scl_d;
    assign start_c = scl & st_reg.scl_d & st_reg.sda_d & ~sda;
    assign stop_c = scl & st_reg.scl_d & ~st_reg.sda_d & sda;
    assign a7 = st_reg.shift[7:1];

    // ==========================================================
    // address match
    always_comb begin
        addr_hit = (a7 == {OWN_ADDR_HI[2:0], addr_strap})
            || (st_reg.mode1[MODE1_GCALL_BIT] && a7 == st_reg.gcall[7:1])
            || (st_reg.mode1[MODE1_SUB1_BIT] && a7 == st_reg.sub1[7:1])
            || (st_reg.mode1[MODE1_SUB2_BIT] && a7 == st_reg.sub2[7:1])
            || (st_reg.mode1[MODE1_SUB3_BIT] && a7 == st_reg.sub3[7:1]);
    end

    always_comb begin
        case (st_reg.ptr)
            REG_MODE1: rdata = st_reg.mode1;
            REG_MODE2: rdata = st_reg.mode2;
            REG_GDUTY: rdata = st_reg.gduty;
            REG_GFREQ: rdata = st_reg.gfreq;
            REG_OSTATE0: rdata = st_reg.ostate[7:0];
            REG_OSTATE1: rdata = st_reg.ostate[15:8];
            REG_SUB1: rdata = st_reg.sub1;
            REG_SUB2: rdata = st_reg.sub2;
            REG_SUB3: rdata = st_reg.sub3;
            REG_GCALL: rdata = st_reg.gcall;
            default: begin
                if (st_reg.ptr >= REG_DUTY0 && st_reg.ptr <= REG_DUTY7) begin
                    rdata = st_reg.duty[3'(st_reg.ptr - REG_DUTY0)];
                end else begin
                    rdata = 8'h00;
                end
            end
        endcase
    end

    // ==========================================================
    // bus engine and register file
    always_comb begin
        st_next = st_reg;
        st_next.scl_s = {st_reg.scl_s[0], scl_i};
        st_next.sda_s = {st_reg.sda_s[0], sda_i};
        st_next.rst_s = {st_reg.rst_s[0], reset_pin_n};
        st_next.scl_d = scl;
        st_next.sda_d = sda;
        case (st_reg.st)
            LEDD_IDLE: ;
            LEDD_ADDR, LEDD_RX: begin
                if (scl_rise) begin
                    st_next.shift = {st_reg.shift[6:0], sda};
                    st_next.bitc = st_reg.bitc + 4'h1;
                end
                if (scl_fall && st_reg.bitc == 4'h8) begin
                    st_next.bitc = 4'h0;
                    st_next.ack = 1'b0;
                    st_next.st = LEDD_ACK;
                    if (st_reg.st == LEDD_ADDR) begin
                        st_next.rw = st_reg.shift[0];
                        st_next.first = 1'b1;
                        if (a7 == SRST_ADDR) begin
                            st_next.is_srst = 1'b1;
                            st_next.ack = ~st_reg.shift[0];
                        end else begin
                            st_next.ack = addr_hit;
                        end
                    end else if (st_reg.is_srst) begin
                        st_next.srst_cnt = st_reg.srst_cnt == 2'h3 ? 2'h3 : st_reg.srst_cnt + 2'h1;
                        if (st_reg.srst_cnt == 2'h0) begin
                            st_next.ack = st_reg.shift == SRST_BYTE1;
                        end else if (st_reg.srst_cnt == 2'h1) begin
                            st_next.ack = st_reg.shift == SRST_BYTE2;
                            st_next.srst_ok = st_reg.shift == SRST_BYTE2;
                        end else begin
                            st_next.srst_ok = 1'b0;
                        end
                    end else begin
                        st_next.ack = 1'b1;
                        if (st_reg.first) begin
                            st_next.ptr = st_reg.shift[4:0];
                            st_next.first = 1'b0;
                        end else begin
                            case (st_reg.ptr)
                                REG_MODE1: st_next.mode1 = st_reg.shift;
                                REG_MODE2: st_next.mode2 = st_reg.shift;
                                REG_GDUTY: st_next.gduty = st_reg.shift;
                                REG_GFREQ: st_next.gfreq = st_reg.shift;
                                REG_OSTATE0: st_next.ostate[7:0] = st_reg.shift;
                                REG_OSTATE1: st_next.ostate[15:8] = st_reg.shift;
                                REG_SUB1: st_next.sub1 = st_reg.shift;
                                REG_SUB2: st_next.sub2 = st_reg.shift;
                                REG_SUB3: st_next.sub3 = st_reg.shift;
                                REG_GCALL: st_next.gcall = st_reg.shift;
                                default: begin
                                    if (st_reg.ptr >= REG_DUTY0 && st_reg.ptr <= REG_DUTY7) begin
                                        st_next.duty[3'(st_reg.ptr - REG_DUTY0)] = st_reg.shift;
                                    end
                                end
                            endcase
                        end
                    end
                    // a not-acknowledged soft reset byte cancels the call
                    if (st_reg.is_srst && st_reg.st == LEDD_RX && st_reg.srst_cnt != 2'h0
                        && st_reg.srst_cnt != 2'h1) begin
                        st_next.ack = 1'b0;
                    end
                    if (st_reg.is_srst && st_reg.st == LEDD_RX && st_reg.srst_cnt == 2'h0
                        && st_reg.shift != SRST_BYTE1) begin
                        st_next.srst_cnt = 2'h3;
                    end
                    st_next.drive_low = st_next.ack;
                end
            end
            LEDD_ACK: begin
                if (scl_fall) begin
                    st_next.drive_low = 1'b0;
                    if (!st_reg.ack) begin
                        st_next.st = LEDD_IGNORE;
                    end else if (st_reg.rw && !st_reg.is_srst) begin
                        st_next.shift = rdata;
                        st_next.drive_low = ~rdata[7];
                        st_next.st = LEDD_TX;
                    end else begin
                        st_next.st = LEDD_RX;
                    end
                end
            end
            LEDD_TX: begin
                if (scl_fall) begin
                    st_next.bitc = st_reg.bitc + 4'h1;
                    if (st_reg.bitc == 4'h7) begin
                        st_next.bitc = 4'h0;
                        st_next.drive_low = 1'b0;
                        st_next.st = LEDD_MACK;
                    end else begin
                        st_next.shift = {st_reg.shift[6:0], 1'b0};
                        st_next.drive_low = ~st_reg.shift[6];
                    end
                end
            end
            LEDD_MACK: begin
                if (scl_rise) begin
                    st_next.ack = ~sda;
                end
                if (scl_fall) begin
                    if (st_reg.ack) begin
                        st_next.shift = rdata;
                        st_next.drive_low = ~rdata[7];
                        st_next.st = LEDD_TX;
                    end else begin
                        st_next.st = LEDD_IGNORE;
                    end
                end
            end
            LEDD_IGNORE: ;
            default: st_next.st = LEDD_IDLE;
        endcase
        if (start_c) begin
            st_next.st = LEDD_ADDR;
            st_next.bitc = 4'h0;
            st_next.is_srst = 1'b0;
            st_next.srst_cnt = 2'h0;
            st_next.srst_ok = 1'b0;
            st_next.drive_low = 1'b0;
        end
        if (stop_c) begin
            st_next.st = LEDD_IDLE;
            st_next.drive_low = 1'b0;
        end
        st_next.stby = st_reg.ostate == 16'h0000;
        // any reset takes everything else to defaults; only srst also presets the synchronisers
        if (srst || rst_pin || (stop_c && st_reg.is_srst && st_reg.srst_ok
                && st_reg.srst_cnt == 2'h2)) begin
            st_next.st = LEDD_IDLE;
            st_next.bitc = 4'h0;
            st_next.shift = 8'h00;
            st_next.rw = 1'b0;
            st_next.first = 1'b0;
            st_next.is_srst = 1'b0;
            st_next.srst_cnt = 2'h0;
            st_next.srst_ok = 1'b0;
            st_next.ack = 1'b0;
            st_next.drive_low = 1'b0;
            st_next.ptr = 5'h00;
            st_next.mode1 = MODE1_RST;
            st_next.mode2 = MODE2_RST;
            st_next.duty = '0;
            st_next.gduty = GDUTY_RST;
            st_next.gfreq = GFREQ_RST;
            st_next.ostate = 16'h0000;
            st_next.sub1 = SUB1_RST;
            st_next.sub2 = SUB2_RST;
            st_next.sub3 = SUB3_RST;
            st_next.gcall = GCALL_RST;
            st_next.stby = 1'b1;
        end
        if (srst) begin
            st_next.scl_s = 2'h3;
            st_next.sda_s = 2'h3;
            st_next.rst_s = 2'h3;
            st_next.scl_d = 1'b1;
            st_next.sda_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = ~st_reg.drive_low;
    assign standby = st_reg.stby;

    // ==========================================================
    // modulators
    ledd_mod_if tb_if ();
    logic ch_rst;
    assign ch_rst = srst | rst_pin;

    ledd_timebase u_tb (
        .mclk(mclk),
        .srst(ch_rst),
        .gduty(st_reg.gduty),
        .gfreq(st_reg.gfreq),
        .blink(st_reg.mode2[MODE2_BLINK_BIT]),
        .tb(tb_if.src)
    );

    for (genvar i = 0; i < 8; i++) begin : g_ch
        ledd_channel u_ch (
            .mclk(mclk),
            .srst(ch_rst),
            .duty(st_reg.duty[i]),
            .ostate(st_reg.ostate[2*i+1:2*i]),
            .tb(tb_if.dst),
            .led_n(led_n[i])
        );
    end
endmodule

// ===== common/ledd_pkg.sv
// constants, types and state encodings for the led dimmer two-wire target core
// assumes one 200 MHz clock and synchronous active-high reset in every user
// How it works
// - eight channels, each an 8-bit modulator at about 97 kHz, duty 0 to 255/256
// - shared group modulator dims at 190 Hz or blinks at a programmable slow rate
// - each output is off, on, individual modulation, or individual gated by group
// - in group mode the output is active only while both modulators are active
// - one individual modulator step lasts 40 ns
// - one group dimming step lasts 20.48 us
// - when dimming, group duty M yields 2M individual pulses per group period
// - after power-on all registers and the bus machine take defaults, channels off
// - while the reset pin is low, registers and bus machine stay at defaults
// - soft reset address acknowledged only as write, 96h; read form not acknowledged
// - first soft reset data byte must be A5h, else not acknowledged
// - second soft reset data byte must be 5Ah, else not acknowledged
// - no further data bytes of a soft reset call are acknowledged
// - after both good bytes a stop resets registers and bus machine to power-up values; timebase counters keep running
// - a malformed soft reset sequence leaves the registers untouched
// - soft reset leaves outputs as after power-on: all driven high, leds off
// - four strapped address inputs form part of the own target address
// - group call address defaults to 90h, enabled; 90h write and 91h read acked
// - sub call addresses default 92h, 94h, 98h, all disabled after power-up
// - last address bit selects direction: 1 read, 0 write
// - standby reported when every channel is off, active when any is enabled
// - start is data falling with clock high, stop is data rising with clock high
// - as receiver, every addressed byte outside a soft reset call is acknowledged by holding data low
// - a not-acknowledged read byte makes the device release the data line
// - first written byte is the control byte; its low five bits point a register
package ledd_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned IND_STEP_PS = 40000;
    localparam int unsigned GRP_STEP_PS = 20480000;
    // a step is a whole number of clocks; rounded down so no step overruns
    localparam int unsigned IND_STEP_CYC = IND_STEP_PS / CLK_PERIOD_PS;
    localparam int unsigned GRP_STEP_CYC = GRP_STEP_PS / CLK_PERIOD_PS;
    // blink step is (freq+1) slices of 16 individual periods: about 24 Hz to 10.7 s
    localparam int unsigned BLINK_STEP_PER = 16;

    // ==========================================================
    // register indexes
    localparam logic [4:0] REG_MODE1 = 5'h00;
    localparam logic [4:0] REG_MODE2 = 5'h01;
    localparam logic [4:0] REG_DUTY0 = 5'h02;
    localparam logic [4:0] REG_DUTY7 = 5'h09;
    localparam logic [4:0] REG_GDUTY = 5'h0a;
    localparam logic [4:0] REG_GFREQ = 5'h0b;
    localparam logic [4:0] REG_OSTATE0 = 5'h0c;
    localparam logic [4:0] REG_OSTATE1 = 5'h0d;
    localparam logic [4:0] REG_SUB1 = 5'h0e;
    localparam logic [4:0] REG_SUB2 = 5'h0f;
    localparam logic [4:0] REG_SUB3 = 5'h10;
    localparam logic [4:0] REG_GCALL = 5'h11;
    localparam logic [4:0] REG_LAST = 5'h11;

    // mode1 bits
    localparam int MODE1_SUB1_BIT = 3;
    localparam int MODE1_SUB2_BIT = 2;
    localparam int MODE1_SUB3_BIT = 1;
    localparam int MODE1_GCALL_BIT = 0;
    // mode2 bit: 1 selects blinking, 0 dimming
    localparam int MODE2_BLINK_BIT = 5;

    // reset values
    localparam logic [7:0] MODE1_RST = 8'h11;
    localparam logic [7:0] MODE2_RST = 8'h00;
    localparam logic [7:0] GDUTY_RST = 8'hff;
    localparam logic [7:0] GFREQ_RST = 8'h00;
    localparam logic [7:0] GCALL_RST = 8'h90;
    localparam logic [7:0] SUB1_RST = 8'h92;
    localparam logic [7:0] SUB2_RST = 8'h94;
    localparam logic [7:0] SUB3_RST = 8'h98;

    // ==========================================================
    // bus constants
    localparam logic [6:0] SRST_ADDR = 7'h4b;
    localparam logic [7:0] SRST_BYTE1 = 8'ha5;
    localparam logic [7:0] SRST_BYTE2 = 8'h5a;
    localparam logic [2:0] OWN_ADDR_HI = 3'h4;

    // output state codes
    localparam logic [1:0] OST_OFF = 2'h0;
    localparam logic [1:0] OST_ON = 2'h1;
    localparam logic [1:0] OST_IND = 2'h2;
    localparam logic [1:0] OST_GRP = 2'h3;

    typedef enum logic [2:0] {
        LEDD_IDLE,
        LEDD_ADDR,
        LEDD_RX,
        LEDD_TX,
        LEDD_ACK,
        LEDD_MACK,
        LEDD_IGNORE
    } ledd_bus_st_t;

endpackage

// ===== common/ledd_mod_if.sv
// carries the shared modulator timebase from the top to each channel
// assumes the top drives it from one clock domain
`timescale 1ns/1ps
interface ledd_mod_if;
    logic [7:0] ind_step;
    logic grp_active;
    modport src (output ind_step, output grp_active);
    modport dst (input ind_step, input grp_active);
endinterface

// ===== rtl/ledd_timebase.sv
// shared free-running step counters for individual and group modulators
// assumes mclk at 200 MHz and a synchronous reset
`timescale 1ns/1ps
module ledd_timebase
    import ledd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] gduty,
    input wire logic [7:0] gfreq,
    input wire logic blink,
    ledd_mod_if.src tb
);
    typedef struct packed {
        logic [3:0] pre;
        logic [7:0] ind;
        logic [15:0] gpre;
        logic [7:0] grp;
    } ledd_tb_t;

    ledd_tb_t st_reg, st_next;
    logic [15:0] gstep_per;

    // group steps count whole individual periods, keeping both modulators in phase;
    // dimming steps are fixed, blinking stretches each step by freq+1
    always_comb begin
        if (blink) begin
            gstep_per = 16'((32'(gfreq) + 32'd1) * BLINK_STEP_PER);
        end else begin
            gstep_per = 16'(GRP_STEP_CYC / (256 * IND_STEP_CYC));
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.pre = st_reg.pre + 4'h1;
        if (st_reg.pre == 4'(IND_STEP_CYC - 1)) begin
            st_next.pre = 4'h0;
            st_next.ind = st_reg.ind + 8'h01;
            if (st_reg.ind == 8'hff) begin
                st_next.gpre = st_reg.gpre + 16'h0001;
            end
        end
        // >= so that a shorter step chosen mid-count ends at the next individual period end
        if (st_reg.ind == 8'hff && st_reg.pre == 4'(IND_STEP_CYC - 1)
            && st_reg.gpre >= gstep_per - 16'h0001) begin
            st_next.gpre = 16'h0000;
            st_next.grp = st_reg.grp + 8'h01;
        end
        if (srst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    assign tb.ind_step = st_reg.ind;
    // when dimming one group step is 512 individual steps, so M steps hold 2M periods
    assign tb.grp_active = st_reg.grp < gduty;
endmodule

// ===== rtl/ledd_channel.sv
// one output channel: compares shared step against its duty and applies the mode
// assumes the timebase interface is driven on the same clock
`timescale 1ns/1ps
module ledd_channel
    import ledd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] duty,
    input wire logic [1:0] ostate,
    ledd_mod_if.dst tb,
    output logic led_n
);
    typedef struct packed {
        logic out_n;
    } ledd_ch_t;

    ledd_ch_t st_reg, st_next;
    logic pwm_on;

    always_comb begin
        pwm_on = tb.ind_step < duty;
        st_next = st_reg;
        case (ostate)
            OST_OFF: st_next.out_n = 1'b1;
            OST_ON: st_next.out_n = 1'b0;
            OST_IND: st_next.out_n = ~pwm_on;
            OST_GRP: st_next.out_n = ~(pwm_on & tb.grp_active);
            default: st_next.out_n = 1'b1;
        endcase
        if (srst) begin
            st_next.out_n = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    assign led_n = st_reg.out_n;
endmodule

// ===== verif/ledd_bus_ctrl.sv
// bus controller model that drives scl and its own pull on sda
// assumes a pull-up on sda: the wire is low when either side pulls it low
`timescale 1ns/1ps
module ledd_bus_ctrl (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    logic [7:0] res;
    event got;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // eight clocks a half period keeps both synced lines well apart
    task automatic half(input logic lvl);
        repeat (8) @(negedge mclk);
        scl = lvl;
    endtask
    // sda moves two clocks after scl falls, so the synced lines never fake a start
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(negedge mclk);
        sda_drv = b;
        half(1'b1);
        repeat (4) @(posedge mclk);
        r = sda;
        half(1'b0);
    endtask
    task automatic start();
        repeat (2) @(negedge mclk);
        sda_drv = 1'b1;
        half(1'b1);
        repeat (4) @(negedge mclk);
        sda_drv = 1'b0;
        half(1'b0);
    endtask
    task automatic stop();
        repeat (2) @(negedge mclk);
        sda_drv = 1'b0;
        half(1'b1);
        repeat (8) @(negedge mclk);
        sda_drv = 1'b1;
        repeat (16) @(negedge mclk);
    endtask
    task automatic xb(input logic [7:0] d, input logic ack_out, input logic rd);
        logic [7:0] v;
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], v[i]);
        end
        bit_io(ack_out, a);
        res = rd ? v : {7'h00, a};
        -> got;
    endtask
endmodule

// ===== verif/ledd_core_chk.sv
// port checker for the led dimmer target core
// assumes one mclk domain with srst synchronous and active high
`timescale 1ns/1ps
module ledd_core_chk
    import ledd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic [3:0] addr_strap,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic [7:0] led_n,
    input wire logic standby
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [7:0] low_run;
    // a stuck pull-down would hang every device on the bus
    always_ff @(posedge mclk) begin
        low_run <= (srst || sda_oe_n) ? 8'h00 : low_run + 8'h01;
    end
    a_rst_defaults: assert property ($fell(srst) |-> led_n == 8'hff && standby && sda_oe_n)
        else $error("outputs not at defaults after reset");
    a_pin_hold: assert property (!reset_pin_n [*5] |-> led_n == 8'hff && standby)
        else $error("outputs not held while reset pin low");
    a_pin_bus: assert property (!reset_pin_n [*5] |-> sda_oe_n)
        else $error("sda pulled while reset pin low");
    a_sda_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
        else $error("sda pull changed while scl high");
    a_pull_start: assert property ($fell(sda_oe_n) |-> !scl_i && !$past(scl_i))
        else $error("sda pull began outside scl low");
    a_drive_low: assert property (sda_o == 1'b0)
        else $error("sda driven to a high level");
    a_pull_bound: assert property (low_run < 8'd200)
        else $error("sda held low too long");
    a_standby_dark: assert property (standby [*3] |-> led_n == 8'hff)
        else $error("led lit during standby");
endmodule
bind ledd_core ledd_core_chk i_chk (.mclk(mclk), .srst(srst), .reset_pin_n(reset_pin_n),
    .addr_strap(addr_strap), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .led_n(led_n), .standby(standby));

// ===== verif/ledd_core_test.sv
// self-checking bench for the led dimmer target core
// assumes the controller model in ledd_bus_ctrl and a pull-up on sda
`timescale 1ns/1ps
module ledd_core_test;
    import ledd_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic [3:0] addr_strap = 4'h0;
    logic sda_o, sda_oe_n, standby, sda_i, scl, drv;
    logic [7:0] led_n, n;
    logic [15:0] lows;
    logic [7:0] exq[$];
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 mclk = ~mclk;
    assign sda_i = drv & (sda_oe_n | sda_o);
    ledd_core i_dut (.mclk(mclk), .srst(srst), .reset_pin_n(reset_pin_n),
        .addr_strap(addr_strap), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .led_n(led_n), .standby(standby));
    ledd_bus_ctrl i_ctrl (.mclk(mclk), .sda(sda_i), .scl(scl), .sda_drv(drv));
    task automatic close_out();
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        num_checks++;
        if (a !== e) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, a, e);
        end
    endtask
    always @(i_ctrl.got) chk(16'(i_ctrl.res), 16'(exq.pop_front()));
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            close_out();
        end
    end
    // ==========================================================
    // bus helpers: expectations are queued before the byte goes out
    task automatic wb(input logic [7:0] d, input logic nack);
        exq.push_back({7'h00, nack});
        i_ctrl.xb(d, 1'b1, 1'b0);
    endtask
    task automatic wreg(input logic [4:0] r, input logic [7:0] v);
        i_ctrl.start();
        wb({OWN_ADDR_HI, addr_strap, 1'b0}, 1'b0);
        wb({3'h0, r}, 1'b0);
        wb(v, 1'b0);
        i_ctrl.stop();
    endtask
    task automatic sw(input logic [7:0] b0, b1, b2, input int k, input logic [2:0] nk);
        logic [7:0] b [3];
        b = '{b0, b1, b2};
        i_ctrl.start();
        wb({SRST_ADDR, 1'b0}, 1'b0);
        for (int j = 0; j < k; j++) begin
            wb(b[j], nk[j]);
        end
        i_ctrl.stop();
    endtask
    // one full modulator period, so the count does not depend on phase
    task automatic count_lows();
        lows = 16'h0000;
        repeat (256 * IND_STEP_CYC) @(posedge mclk) lows += 16'(!led_n[0]);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'h070b8e19));
        // low straps keep the own address clear of the call addresses
        addr_strap = 4'($urandom_range(7, 0));
        n = 8'($urandom_range(255, 1));
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        repeat (8) @(negedge mclk);
        chk(16'({led_n, standby}), 16'h01ff);
        i_ctrl.start();
        wb(SUB1_RST, 1'b1);
        i_ctrl.start();
        wb({SRST_ADDR, 1'b1}, 1'b1);
        i_ctrl.start();
        wb(GCALL_RST | 8'h01, 1'b0);
        exq.push_back(MODE1_RST);
        i_ctrl.xb(8'hff, 1'b1, 1'b1);
        i_ctrl.stop();
        wreg(REG_DUTY0, n);
        wreg(REG_OSTATE0, {6'h00, OST_IND});
        chk(16'(standby), 16'h0000);
        count_lows();
        chk(lows, 16'(n) * 16'(IND_STEP_CYC));
        wreg(REG_OSTATE0, {6'h00, OST_ON});
        count_lows();
        chk(lows, 16'(256 * IND_STEP_CYC));
        wreg(REG_GDUTY, 8'h00);
        wreg(REG_OSTATE0, {6'h00, OST_GRP});
        repeat (GRP_STEP_CYC) @(negedge mclk);
        count_lows();
        chk(lows, 16'h0000);
        sw(8'h00, 8'h00, 8'h00, 1, 3'b001);
        sw(SRST_BYTE1, 8'h00, 8'h00, 2, 3'b010);
        sw(SRST_BYTE1, SRST_BYTE2, SRST_BYTE2, 3, 3'b100);
        chk(16'(standby), 16'h0000);
        sw(SRST_BYTE1, SRST_BYTE2, 8'h00, 2, 3'b000);
        chk(16'({led_n, standby}), 16'h01ff);
        wreg(REG_MODE1, MODE1_RST | 8'h08);
        i_ctrl.start();
        wb(SUB1_RST, 1'b0);
        i_ctrl.stop();
        wreg(REG_OSTATE0, {6'h00, OST_ON});
        reset_pin_n = 1'b0;
        repeat (10) @(negedge mclk);
        chk(16'({led_n, standby}), 16'h01ff);
        reset_pin_n = 1'b1;
        repeat (8) @(negedge mclk);
        i_ctrl.start();
        wb(SUB1_RST, 1'b1);
        i_ctrl.stop();
        close_out();
    end
endmodule
